// file: rtl/cwd_decoder.sv
// Notes on behaviour
// - Primary word is fourteen bits at configuration index 2007h.
// - Bit 13 zero protects all program memory up to 1FFFh or 0FFFh.
// - Primary bits 10-9 and secondary 13-7, 5-2 read as one.
// - Bits 8-7 pick trip level 2.0, 2.7, 4.2 or 4.5 volts.
// - Enable pair 11 keeps brown-out reset always on.
// - Enable pair 10 runs brown-out reset but drops it during sleep.
// - Pair 01 hands brown-out reset to a software bit; 00 disables it.
// - Bit 5 one makes port E pin 3 external reset, else plain input.
// - Bit 3 zero enables the power-up timer.
// - Bit 2 one enables the watchdog.
// - Oscillator codes 111 and 110 are external RC, clock out or port I/O.
// - Codes 101 and 100 are internal RC; pin 7 I/O, pin 6 clock out or I/O.
// - Code 011 external clock, 010 fast, 001 standard, 000 low-power crystal.
// - Secondary word at 2008h holds the brown-out soft enable at bit 6.
// - Secondary bit 1 enables clock switch-over.
// - Secondary bit 0 enables the fail-safe clock monitor.
`timescale 1ns/10ps
`default_nettype none
module cwd_decoder (
  // Clock and reset
  input  wire logic           ref_clk,
  input  wire logic           arst_n,
  // APB slave
  input  wire logic           psel,
  input  wire logic           penable,
  input  wire logic           pwrite,
  input  wire logic [17:0]    paddr,
  input  wire logic [31:0]    pwdata,
  output logic      [31:0]    prdata,
  output logic                pready,
  output logic                pslverr,
  // Non-volatile words and strap
  input  wire logic [13:0]    nv_primary_word,
  input  wire logic [13:0]    nv_secondary_word,
  input  wire logic           large_part_strap,
  // Runtime inputs
  input  wire logic           sleep_active,
  input  wire logic           port_e_pin3_in,
  // Decoded settings
  output logic                config_valid_q,
  output logic                program_protect_q,
  output logic      [12:0]    protect_top_q,
  output logic                capture_on_port_c_pin1_q,
  output logic                capture_on_port_b_pin3_q,
  output logic      [1:0]     brownout_threshold_select_q,
  output logic      [12:0]    brownout_trip_level_q,
  output logic                brownout_reset_en_q,
  output logic                reset_pin_select_q,
  output logic                external_reset_q,
  output logic                port_e_pin3_q,
  output logic                powerup_timer_en_q,
  output logic                watchdog_enable_q,
  output cwd_pkg::cwd_osc_t   oscillator_mode_q,
  output logic                clock_out_en_q,
  output logic                port_a_pin6_io_q,
  output logic                port_a_pin7_io_q,
  output logic                clock_switchover_enable_q,
  output logic                failsafe_monitor_enable_q
);
  cwd_pkg::cwd_state_t state_q;
  logic [1:0]  settle_q;
  logic [13:0] pri_s1_q;
  logic [13:0] pri_s2_q;
  logic [13:0] sec_s1_q;
  logic [13:0] sec_s2_q;
  logic        strap_s1_q;
  logic        strap_s2_q;
  logic        pin_s1_q;
  logic        pin_s2_q;
  logic [13:0] cfg_pri_q;
  logic [13:0] cfg_sec_q;
  logic        reserved_fault_q;
  logic        runtime_brownout_control_q;
  logic [31:0] prdata_q;
  logic        pready_q;
  logic        pslverr_q;
  logic [13:0] store_rdata;

  // Pins and the non-volatile array sit outside this clock
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pri_s1_q   <= cwd_pkg::ERASED_WORD;
      pri_s2_q   <= cwd_pkg::ERASED_WORD;
      sec_s1_q   <= cwd_pkg::ERASED_WORD;
      sec_s2_q   <= cwd_pkg::ERASED_WORD;
      strap_s1_q <= 1'h0;
      strap_s2_q <= 1'h0;
      pin_s1_q   <= 1'h1;
      pin_s2_q   <= 1'h1;
    end
    else
    begin
      pri_s1_q   <= nv_primary_word;
      pri_s2_q   <= pri_s1_q;
      sec_s1_q   <= nv_secondary_word;
      sec_s2_q   <= sec_s1_q;
      strap_s1_q <= large_part_strap;
      strap_s2_q <= strap_s1_q;
      pin_s1_q   <= port_e_pin3_in;
      pin_s2_q   <= pin_s1_q;
    end
  end

  // Load sequencing
  wire logic in_run   = (state_q == cwd_pkg::ST_RUN);
  wire logic load_pri = (state_q == cwd_pkg::ST_LOAD_PRI);
  wire logic load_sec = (state_q == cwd_pkg::ST_LOAD_SEC);

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_q  <= cwd_pkg::ST_SYNC;
      settle_q <= 2'h0;
    end
    else
    begin
      case (state_q)
        cwd_pkg::ST_SYNC:
        begin
          settle_q <= settle_q + 2'h1;
          if (settle_q == cwd_pkg::SETTLE_CYCLES)
            state_q <= cwd_pkg::ST_LOAD_PRI;
        end
        cwd_pkg::ST_LOAD_PRI: state_q <= cwd_pkg::ST_LOAD_SEC;
        cwd_pkg::ST_LOAD_SEC: state_q <= cwd_pkg::ST_RUN;
        default: state_q <= cwd_pkg::ST_RUN;
      endcase
    end
  end

  // Words are captured once; later changes on the array wait for a new reset
  cwd_store u_store (
    .ref_clk (ref_clk),
    .arst_n  (arst_n),
    .we      (load_pri || load_sec),
    .waddr   (load_sec),
    .wdata   (load_sec ? sec_s2_q : pri_s2_q),
    .raddr   (paddr == cwd_pkg::ADDR_SECONDARY),
    .rdata_q (store_rdata)
  );

  // Decode of the synchronised words
  wire logic [2:0] osc_code = {pri_s2_q[cwd_pkg::P_OSC_HI], pri_s2_q[cwd_pkg::P_OSC_LO +: 2]};
  wire logic [1:0] thr_code = pri_s2_q[cwd_pkg::P_THR_LO +: 2];
  wire cwd_pkg::cwd_osc_t dec_osc =
    (osc_code[2:1] == 2'h3)            ? cwd_pkg::OM_EXTERNAL_RC :
    (osc_code[2:1] == 2'h2)            ? cwd_pkg::OM_INTERNAL_RC :
    (osc_code == cwd_pkg::OSC_EXT_CLOCK) ? cwd_pkg::OM_EXTERNAL_CLK :
    (osc_code == cwd_pkg::OSC_FAST_XTAL) ? cwd_pkg::OM_HIGH_SPEED :
    (osc_code == cwd_pkg::OSC_STD_XTAL)  ? cwd_pkg::OM_STANDARD : cwd_pkg::OM_LOW_POWER;
  wire logic dec_clkout = (osc_code == cwd_pkg::OSC_ERC_CLKOUT) || (osc_code == cwd_pkg::OSC_IRC_CLKOUT);
  wire logic dec_pin6_io = (osc_code == cwd_pkg::OSC_ERC_IO) || (osc_code == cwd_pkg::OSC_IRC_IO)
                        || (osc_code == cwd_pkg::OSC_EXT_CLOCK);
  wire logic dec_pin7_io = (osc_code[2:1] == 2'h2);
  wire logic [12:0] dec_trip =
    (thr_code == 2'h3) ? cwd_pkg::TRIP_MV_11 :
    (thr_code == 2'h2) ? cwd_pkg::TRIP_MV_10 :
    (thr_code == 2'h1) ? cwd_pkg::TRIP_MV_01 : cwd_pkg::TRIP_MV_00;
  wire logic dec_protect = !pri_s2_q[cwd_pkg::P_PROTECT];

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cfg_pri_q                   <= cwd_pkg::ERASED_WORD;
      cfg_sec_q                   <= cwd_pkg::ERASED_WORD;
      program_protect_q           <= 1'h0;
      protect_top_q               <= 13'h0000;
      capture_on_port_c_pin1_q    <= 1'h0;
      capture_on_port_b_pin3_q    <= 1'h0;
      brownout_threshold_select_q <= 2'h0;
      brownout_trip_level_q       <= 13'h0000;
      reset_pin_select_q          <= 1'h0;
      powerup_timer_en_q          <= 1'h0;
      watchdog_enable_q           <= 1'h0;
      oscillator_mode_q           <= cwd_pkg::OM_LOW_POWER;
      clock_out_en_q              <= 1'h0;
      port_a_pin6_io_q            <= 1'h0;
      port_a_pin7_io_q            <= 1'h0;
      clock_switchover_enable_q   <= 1'h0;
      failsafe_monitor_enable_q   <= 1'h0;
      reserved_fault_q            <= 1'h0;
      config_valid_q              <= 1'h0;
    end
    else if (load_sec)
    begin
      cfg_pri_q                   <= pri_s2_q;
      cfg_sec_q                   <= sec_s2_q;
      program_protect_q           <= dec_protect;
      protect_top_q               <= !dec_protect ? 13'h0000 :
                                     strap_s2_q ? cwd_pkg::PROTECT_TOP_LARGE : cwd_pkg::PROTECT_TOP_SMALL;
      capture_on_port_c_pin1_q    <= pri_s2_q[cwd_pkg::P_CAPMUX];
      capture_on_port_b_pin3_q    <= !pri_s2_q[cwd_pkg::P_CAPMUX];
      brownout_threshold_select_q <= thr_code;
      brownout_trip_level_q       <= dec_trip;
      reset_pin_select_q          <= pri_s2_q[cwd_pkg::P_RESET_PIN];
      powerup_timer_en_q          <= !pri_s2_q[cwd_pkg::P_PWRUP];
      watchdog_enable_q           <= pri_s2_q[cwd_pkg::P_WATCHDOG];
      oscillator_mode_q           <= dec_osc;
      clock_out_en_q              <= dec_clkout;
      port_a_pin6_io_q            <= dec_pin6_io;
      port_a_pin7_io_q            <= dec_pin7_io;
      clock_switchover_enable_q   <= sec_s2_q[cwd_pkg::S_SWITCHOVER];
      failsafe_monitor_enable_q   <= sec_s2_q[cwd_pkg::S_FAILSAFE];
      // A cleared reserved bit is flagged only; behaviour is not defined for it
      reserved_fault_q            <= !pri_s2_q[cwd_pkg::P_RESERVED];
      config_valid_q              <= 1'h1;
    end
  end

  // Brown-out reset and reset pin follow live conditions once loaded
  wire logic [1:0] brown_pair = {cfg_pri_q[cwd_pkg::P_BROWN_EN], cfg_sec_q[cwd_pkg::S_BROWN_SOFT]};
  wire logic brown_now =
    (brown_pair == cwd_pkg::BROWN_ALWAYS)  ? 1'h1 :
    (brown_pair == cwd_pkg::BROWN_RUNNING) ? !sleep_active :
    (brown_pair == cwd_pkg::BROWN_SOFT)    ? runtime_brownout_control_q : 1'h0;
  wire logic pin_is_reset = cfg_pri_q[cwd_pkg::P_RESET_PIN];

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      brownout_reset_en_q <= 1'h0;
      external_reset_q    <= 1'h0;
      port_e_pin3_q       <= 1'h0;
    end
    else
    begin
      brownout_reset_en_q <= in_run && brown_now;
      // Pin low means reset asserted; as plain input the reset stays inactive
      external_reset_q    <= in_run && pin_is_reset && !pin_s2_q;
      port_e_pin3_q       <= in_run && !pin_is_reset && pin_s2_q;
    end
  end

  // APB decode; one wait state so read data can leave a flip-flop
  wire logic hit_pri  = (paddr == cwd_pkg::ADDR_PRIMARY);
  wire logic hit_sec  = (paddr == cwd_pkg::ADDR_SECONDARY);
  wire logic hit_ctrl = (paddr == cwd_pkg::ADDR_CTRL);
  wire logic hit_stat = (paddr == cwd_pkg::ADDR_STATUS);
  wire logic access   = psel && penable;
  wire logic bad_req  = !(hit_pri || hit_sec || hit_ctrl || hit_stat) || (pwrite && !hit_ctrl);
  wire logic [31:0] rd_mux =
    hit_pri  ? {18'h00000, store_rdata | cwd_pkg::PRIMARY_ONES} :
    hit_sec  ? {18'h00000, store_rdata | cwd_pkg::SECONDARY_ONES} :
    hit_ctrl ? {31'h00000000, runtime_brownout_control_q} :
    hit_stat ? {29'h00000000, reserved_fault_q, brownout_reset_en_q, config_valid_q} : 32'h00000000;
  wire logic do_write = access && pready_q && pwrite && hit_ctrl;

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      prdata_q  <= 32'h00000000;
      pready_q  <= 1'h0;
      pslverr_q <= 1'h0;
    end
    else if (pready_q)
    begin
      pready_q  <= 1'h0;
      pslverr_q <= 1'h0;
    end
    else if (access)
    begin
      pready_q  <= 1'h1;
      pslverr_q <= bad_req;
      prdata_q  <= pwrite ? 32'h00000000 : rd_mux;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      runtime_brownout_control_q <= cwd_pkg::CTRL_RESET;
    else if (do_write)
      runtime_brownout_control_q <= pwdata[cwd_pkg::CTRL_SOFT_BROWN];
  end

  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!arst_n);

  sequence s_load;
    state_q == cwd_pkg::ST_LOAD_SEC;
  endsequence

  property p_load_words;
    s_load |=> (cfg_pri_q == $past(pri_s2_q)) && (cfg_sec_q == $past(sec_s2_q)) && config_valid_q;
  endproperty
  a_load_words: assert property (p_load_words) else $error("words not captured at load");

  property p_hold;
    in_run |=> $stable(watchdog_enable_q) && $stable(oscillator_mode_q) && $stable(cfg_pri_q)
               && $stable(program_protect_q) && $stable(failsafe_monitor_enable_q);
  endproperty
  a_hold: assert property (p_hold) else $error("setting changed after load");

  property p_pri_ones;
    access && pready_q && !pwrite && hit_pri |-> prdata[10:9] == 2'h3;
  endproperty
  a_pri_ones: assert property (p_pri_ones) else $error("primary unused bits not one");

  property p_sec_ones;
    access && pready_q && !pwrite && hit_sec |-> (prdata[13:0] & cwd_pkg::SECONDARY_ONES) == cwd_pkg::SECONDARY_ONES;
  endproperty
  a_sec_ones: assert property (p_sec_ones) else $error("secondary unused bits not one");

  property p_brown_always;
    in_run && brown_pair == cwd_pkg::BROWN_ALWAYS |=> brownout_reset_en_q [*2];
  endproperty
  a_brown_always: assert property (p_brown_always) else $error("brown-out not always on");

  property p_brown_sleep;
    in_run && brown_pair == cwd_pkg::BROWN_RUNNING && sleep_active |=> !brownout_reset_en_q;
  endproperty
  a_brown_sleep: assert property (p_brown_sleep) else $error("brown-out active in sleep");

  property p_brown_soft;
    in_run && brown_pair == cwd_pkg::BROWN_SOFT |=> brownout_reset_en_q == $past(runtime_brownout_control_q);
  endproperty
  a_brown_soft: assert property (p_brown_soft) else $error("brown-out ignores soft bit");

  property p_brown_off;
    in_run && brown_pair == 2'h0 |=> !brownout_reset_en_q;
  endproperty
  a_brown_off: assert property (p_brown_off) else $error("brown-out on while disabled");

  property p_pin_input;
    in_run && !cfg_pri_q[cwd_pkg::P_RESET_PIN] |=> !external_reset_q;
  endproperty
  a_pin_input: assert property (p_pin_input) else $error("reset from input-only pin");

  property p_protect;
    config_valid_q |-> program_protect_q == !cfg_pri_q[cwd_pkg::P_PROTECT]
                       && (program_protect_q || protect_top_q == 13'h0000);
  endproperty
  a_protect: assert property (p_protect) else $error("protection mismatch");

  property p_timers;
    config_valid_q |-> powerup_timer_en_q == !cfg_pri_q[cwd_pkg::P_PWRUP]
                       && watchdog_enable_q == cfg_pri_q[cwd_pkg::P_WATCHDOG];
  endproperty
  a_timers: assert property (p_timers) else $error("timer enables mismatch");

  property p_clkout;
    config_valid_q && cfg_pri_q[cwd_pkg::P_OSC_HI] && cfg_pri_q[cwd_pkg::P_OSC_LO] |-> clock_out_en_q && !port_a_pin6_io_q;
  endproperty
  a_clkout: assert property (p_clkout) else $error("clock out pin wrong");

  property p_ack;
    access && !pready_q |=> pready_q ##1 !pready_q;
  endproperty
  a_ack: assert property (p_ack) else $error("bus answer timing wrong");
endmodule // cwd_decoder
`default_nettype wire

// file: include/cwd_pkg.sv
`default_nettype none
package cwd_pkg;
  // Word indices; the bus byte address is four times the index
  localparam logic [15:0] IDX_PRIMARY   = 16'h2007;
  localparam logic [15:0] IDX_SECONDARY = 16'h2008;
  localparam logic [15:0] IDX_CTRL      = 16'h2009;
  localparam logic [15:0] IDX_STATUS    = 16'h200a;
  localparam logic [17:0] ADDR_PRIMARY   = {IDX_PRIMARY, 2'h0};
  localparam logic [17:0] ADDR_SECONDARY = {IDX_SECONDARY, 2'h0};
  localparam logic [17:0] ADDR_CTRL      = {IDX_CTRL, 2'h0};
  localparam logic [17:0] ADDR_STATUS    = {IDX_STATUS, 2'h0};
  localparam int WORD_W = 14;
  // Primary word fields
  localparam int P_PROTECT   = 13;
  localparam int P_CAPMUX    = 12;
  localparam int P_RESERVED  = 11;
  localparam int P_THR_LO    = 7;
  localparam int P_BROWN_EN  = 6;
  localparam int P_RESET_PIN = 5;
  localparam int P_OSC_HI    = 4;
  localparam int P_PWRUP     = 3;
  localparam int P_WATCHDOG  = 2;
  localparam int P_OSC_LO    = 0;
  // Secondary word fields
  localparam int S_BROWN_SOFT = 6;
  localparam int S_SWITCHOVER = 1;
  localparam int S_FAILSAFE   = 0;
  // Unimplemented positions that read as one
  localparam logic [13:0] PRIMARY_ONES   = 14'h0600;
  localparam logic [13:0] SECONDARY_ONES = 14'h3fbc;
  localparam logic [13:0] ERASED_WORD    = 14'h3fff;
  localparam logic [12:0] PROTECT_TOP_LARGE = 13'h1fff;
  localparam logic [12:0] PROTECT_TOP_SMALL = 13'h0fff;
  // Trip levels in millivolts
  localparam logic [12:0] TRIP_MV_11 = 13'h07d0;
  localparam logic [12:0] TRIP_MV_10 = 13'h0a8c;
  localparam logic [12:0] TRIP_MV_01 = 13'h1068;
  localparam logic [12:0] TRIP_MV_00 = 13'h1194;
  localparam logic [1:0] BROWN_ALWAYS = 2'h3;
  localparam logic [1:0] BROWN_RUNNING = 2'h2;
  localparam logic [1:0] BROWN_SOFT = 2'h1;
  localparam logic [2:0] OSC_ERC_CLKOUT = 3'h7;
  localparam logic [2:0] OSC_ERC_IO     = 3'h6;
  localparam logic [2:0] OSC_IRC_CLKOUT = 3'h5;
  localparam logic [2:0] OSC_IRC_IO     = 3'h4;
  localparam logic [2:0] OSC_EXT_CLOCK  = 3'h3;
  localparam logic [2:0] OSC_FAST_XTAL  = 3'h2;
  localparam logic [2:0] OSC_STD_XTAL   = 3'h1;
  localparam int CTRL_SOFT_BROWN = 0;
  localparam logic CTRL_RESET = 1'h0;
  localparam logic [1:0] SETTLE_CYCLES = 2'h2;
  typedef enum logic [3:0] {
    ST_SYNC     = 4'h1,
    ST_LOAD_PRI = 4'h2,
    ST_LOAD_SEC = 4'h4,
    ST_RUN      = 4'h8
  } cwd_state_t;
  typedef enum logic [5:0] {
    OM_EXTERNAL_RC  = 6'h01,
    OM_INTERNAL_RC  = 6'h02,
    OM_EXTERNAL_CLK = 6'h04,
    OM_HIGH_SPEED   = 6'h08,
    OM_STANDARD     = 6'h10,
    OM_LOW_POWER    = 6'h20
  } cwd_osc_t;
endpackage
`default_nettype wire

// file: rtl/cwd_store.sv
`timescale 1ns/10ps
`default_nettype none
module cwd_store (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        arst_n,
  // Write side
  input  wire logic        we,
  input  wire logic        waddr,
  input  wire logic [13:0] wdata,
  // Read side
  input  wire logic        raddr,
  output logic      [13:0] rdata_q
);
  logic [13:0] mem_q [2];

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_entry
      // An unloaded entry reads like erased non-volatile cells
      always_ff @(posedge ref_clk or negedge arst_n)
      begin
        if (!arst_n)
          mem_q[gi] <= cwd_pkg::ERASED_WORD;
        else if (we && (waddr == 1'(gi)))
          mem_q[gi] <= wdata;
      end
    end
  endgenerate

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      rdata_q <= cwd_pkg::ERASED_WORD;
    else
      rdata_q <= mem_q[raddr];
  end
endmodule // cwd_store
`default_nettype wire

// file: tb/cwd_prog_model.sv
`timescale 1ns/10ps
`default_nettype none
module cwd_prog_model (
  // Wanted settings
  input  wire logic        bad_reserved,
  input  wire logic [13:0] want_pri,
  input  wire logic [13:0] want_sec,
  // Programmed words
  output logic      [13:0] nv_primary_word,
  output logic      [13:0] nv_secondary_word
);
  // Reserved bit kept at one unless a test asks for the unsupported zero
  assign nv_primary_word   = {want_pri[13:12], ~bad_reserved, 2'h3, want_pri[8:0]};
  assign nv_secondary_word = {7'h7f, want_sec[6], 4'hf, want_sec[1:0]};
endmodule // cwd_prog_model
`default_nettype wire

// file: tb/test_config_word_decoder.sv
`timescale 1ns/10ps
`default_nettype none
module test_config_word_decoder;
  logic ref_clk, arst_n, psel, penable, pwrite, pready, pslverr;
  logic [17:0] paddr;
  logic [31:0] pwdata, prdata, seed;
  logic [13:0] nv_p, nv_s, want_pri, want_sec;
  logic strap, sleep_active, pin, bad, cfg_valid, prot, cap_c, cap_b, bo_en, rsel, ext_rst, pe3;
  logic pwr, wdt, clock_out, pa6, pa7, sw, fs;
  logic [12:0] top, trip;
  logic [1:0] thr;
  cwd_pkg::cwd_osc_t osc;
  logic [47:0] sq[$];
  logic [33:0] aq[$];
  logic [33:0] e_apb;
  int mismatches, cmp_count;

  cwd_prog_model prog (.bad_reserved(bad), .want_pri(want_pri), .want_sec(want_sec),
    .nv_primary_word(nv_p), .nv_secondary_word(nv_s));
  cwd_decoder uut (.ref_clk(ref_clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .nv_primary_word(nv_p), .nv_secondary_word(nv_s), .large_part_strap(strap),
    .sleep_active(sleep_active), .port_e_pin3_in(pin), .config_valid_q(cfg_valid),
    .program_protect_q(prot), .protect_top_q(top), .capture_on_port_c_pin1_q(cap_c),
    .capture_on_port_b_pin3_q(cap_b), .brownout_threshold_select_q(thr), .brownout_trip_level_q(trip),
    .brownout_reset_en_q(bo_en), .reset_pin_select_q(rsel), .external_reset_q(ext_rst),
    .port_e_pin3_q(pe3), .powerup_timer_en_q(pwr), .watchdog_enable_q(wdt), .oscillator_mode_q(osc),
    .clock_out_en_q(clock_out), .port_a_pin6_io_q(pa6), .port_a_pin7_io_q(pa7),
    .clock_switchover_enable_q(sw), .failsafe_monitor_enable_q(fs));

  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic [47:0] exp_set(logic [13:0] p, logic [13:0] s, logic st, logic pn);
    logic [2:0] c;
    logic [12:0] tr;
    logic [5:0] om;
    c = {p[4], p[1:0]};
    tr = p[8] ? (p[7] ? cwd_pkg::TRIP_MV_11 : cwd_pkg::TRIP_MV_10)
              : (p[7] ? cwd_pkg::TRIP_MV_01 : cwd_pkg::TRIP_MV_00);
    om = c[2] ? (c[1] ? 6'h01 : 6'h02) : (6'h20 >> c[1:0]);
    return {~p[13], p[13] ? 13'h0000 : (st ? 13'h1fff : 13'h0fff), p[12], ~p[12], p[8:7], tr,
            p[5], p[5] & ~pn, ~p[5] & pn, ~p[3], p[2], om, c == 3'h7 || c == 3'h5,
            c == 3'h6 || c == 3'h4 || c == 3'h3, c == 3'h5 || c == 3'h4, s[1:0], p[6]};
  endfunction

  task automatic chk(input string nm, input logic [47:0] exp, input logic [47:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Called right after a rising edge; leaves one idle cycle behind
  task automatic apb(input logic wr, input logic [17:0] a, input logic [31:0] d, input logic [32:0] e);
    int n;
    n = 0;
    aq.push_back({wr, e});
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (n >= 20)
      chk("apb_wait", 48'h0, 48'h1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask

  always @(posedge ref_clk)
    if (psel && penable && pready === 1'b1 && aq.size() > 0)
    begin
      e_apb = aq.pop_front();
      chk("pslverr", {47'h0, e_apb[32]}, {47'h0, pslverr});
      if (!e_apb[33])
        chk("prdata", {16'h0, e_apb[31:0]}, {16'h0, prdata});
    end

  // Live outputs settle one edge after the load, so look two edges on
  always
  begin
    @(posedge cfg_valid);
    repeat (2) @(posedge ref_clk);
    #1;
    chk("settings", sq.pop_front(), {prot, top, cap_c, cap_b, thr, trip, rsel, ext_rst, pe3, pwr, wdt, osc,
        clock_out, pa6, pa7, sw,
        fs, bo_en});
  end

  initial
  begin
    #100us;
    mismatches++;
    conclude();
  end

  initial
  begin
    logic [31:0] r;
    logic [13:0] wp, ws, ep, es;
    int n;
    {psel, penable, pwrite, paddr, pwdata, strap, sleep_active, pin, bad} = '0;
    {want_pri, want_sec} = '0;
    arst_n = 1'b0;
    seed = 32'd51;
    @(posedge ref_clk);
    for (int k = 0; k < 8; k++)
    begin
      r = xs();
      wp = {r[13:12], 3'h0, r[8:7], k[0], r[5], k[2], r[3:2], k[1:0]};
      ws = {r[27:21], k[1], r[19:14]};
      ep = {wp[13:12], k != 7, 2'h3, wp[8:0]};
      es = ws | cwd_pkg::SECONDARY_ONES;
      want_pri <= wp;
      want_sec <= ws;
      bad <= (k == 7);
      strap <= r[28];
      pin <= r[29];
      sleep_active <= 1'b0;
      sq.push_back(exp_set(ep, es, r[28], r[29]));
      arst_n <= 1'b0;
      repeat (3) @(posedge ref_clk);
      arst_n <= 1'b1;
      n = 0;
      while (cfg_valid !== 1'b1 && n < 20)
      begin
        @(posedge ref_clk);
        n++;
      end
      chk("config_valid", 48'h1, {47'h0, cfg_valid});
      repeat (3) @(posedge ref_clk);
      apb(1'b0, cwd_pkg::ADDR_PRIMARY, 32'h0, {19'h0, ep});
      apb(1'b0, cwd_pkg::ADDR_SECONDARY, 32'h0, {19'h0, es});
      apb(1'b0, cwd_pkg::ADDR_CTRL, 32'h0, 33'h0);
      want_pri <= ~wp;
      sleep_active <= 1'b1;
      apb(1'b0, cwd_pkg::ADDR_PRIMARY, 32'h0, {19'h0, ep});
      apb(1'b1, cwd_pkg::ADDR_CTRL, {r[31:1], 1'b1}, 33'h0);
      apb(1'b0, cwd_pkg::ADDR_CTRL, 32'h0, 33'h1);
      apb(1'b0, cwd_pkg::ADDR_STATUS, 32'h0, {30'h0, ep[11] ? 3'h0 : 3'h4} | {31'h0, es[6], 1'b1});
      apb(1'b0, {r[31:30], 16'h0}, 32'h0, {1'b1, 32'h0});
      apb(1'b1, cwd_pkg::ADDR_PRIMARY, r, {1'b1, 32'h0});
      apb(1'b0, cwd_pkg::ADDR_PRIMARY, 32'h0, {19'h0, ep});
      $display("config %0d done", k);
    end
    conclude();
  end
endmodule // test_config_word_decoder
`default_nettype wire
